//--- shared/ctcp_pkg.sv
// Package for the cross-trigger coordination port: constants and carrier structs
package ctcp_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 25;
    localparam int unsigned EXEC_TRIG_PULSE_NS = 100;   // Trigger pulse after execute
    localparam int unsigned EXEC_TRIG_CYCLES   =
        (EXEC_TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EXEC_MASK_CYCLES   = EXEC_TRIG_CYCLES + 4; // Covers bus round trip
    localparam int unsigned CNT_W              = 4;
    localparam int unsigned MAX_UNITS          = 32;

    // -------------------------------------------------------------------
    // Route select codes for the two internal trigger lines
    // -------------------------------------------------------------------
    localparam logic [1:0] ROUTE_NONE  = 2'h0;
    localparam logic [1:0] ROUTE_LINEA = 2'h1;
    localparam logic [1:0] ROUTE_LINEB = 2'h2;
    localparam logic [1:0] ROUTE_BOTH  = 2'h3;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [1:0] RST_SYNC = 2'h0;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTCP_IDLE  = 2'b00,   // Coordination off or running freely
        CTCP_RUN   = 2'b01,   // Running, ready released
        CTCP_HALT  = 2'b10,   // Stopped in background, ready pulled low until prepared
        CTCP_ARMED = 2'b11    // Execute seen, waiting for ready to go true
    } ctcp_state_e;

    // Bus line triple, one bit per line, all in the true sense
    typedef struct packed {
        logic trigger;
        logic ready;
        logic execute;
    } ctcp_bus_s;

    // Routing configuration from the unit's configuration logic
    typedef struct packed {
        logic [1:0] bus_out_route;   // Which internal lines drive the bus trigger
        logic [1:0] bus_in_route;    // Which internal lines the bus trigger drives
        logic [1:0] edge_out_route;  // Which internal lines drive the rear trigger
        logic [1:0] edge_in_route;   // Which internal lines the rear trigger drives
        logic       ana_arm_on_b;    // Analyzer arm from internal line b
        logic       emu_brk_on_b;    // Emulator break from internal line b
        logic       bus_brk_direct;  // Bus trigger breaks emulator directly
        logic       edge_brk_direct; // Rear trigger breaks emulator directly
    } ctcp_cfg_s;

endpackage

//--- design/ctcp_sync.sv
// Two-stage synchroniser bank for the bus lines and the rear trigger input
`timescale 1ns/1ps
module ctcp_sync #(
    parameter int unsigned WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // Second stage is the only reader of the first
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

//--- design/ctcp_port.sv
// Cross-trigger and coordination port of the emulator unit
// How it works
// - Bus has trigger, ready, execute; each is driven and sensed by this unit.
// - Bus trigger is low true; we drive it and receive it.
// - Received bus trigger can arm the analyzer or break the emulator.
// - Ready is high true open collector; its level is the AND of units.
// - Unit releases ready once prepared to run; true means everyone is ready.
// - Coordinated unit breaks when ready goes false, stays stopped until true.
// - On a break the unit pulls ready low until prepared to resume.
// - Unit held in reset pulls ready low.
// - Execute is low true, any unit drives it; emulator and analyzer use it.
// - On execute, run from start address when ready returns true.
// - Rear trigger is a rising edge; drives or receives analyzer, receives break.
// - Bus trigger senses level, rear trigger senses rising edges only.
// - After execute, pulse bus trigger always; own inputs ignore that pulse.
// - Both external lines connect to either internal line, and break directly.
// - Scheme works for up to 32 units started and stopped together.
// - Our analyzer trigger can arm other analyzers or break other emulators.
// - Rear instrument signal can arm our analyzer or break our emulator.
// - Internal line a is driven by the analyzer and received by the emulator.
// - With coordination disabled, the emulator ignores execute and ready.
// - When any coordinated unit breaks, every coordinated unit breaks.
`timescale 1ns/1ps
module ctcp_port (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    // Configuration
    input  wire logic                 coord_en,
    input  wire ctcp_pkg::ctcp_cfg_s  cfg,
    // Emulator side
    input  wire logic                 emu_break,
    input  wire logic                 emu_prepared,
    input  wire logic                 emu_in_monitor,
    input  wire logic                 exec_request,
    output logic                      emu_break_req,
    output logic                      emu_run_from_start,
    output logic                      emu_hold,
    // Analyzer side
    input  wire logic                 ana_trigger,
    output logic                      ana_arm,
    output logic                      ana_exec_start,
    // Coordination bus pins, low level true for trigger and execute
    input  wire logic                 bus_trigger_n_in,
    output logic                      bus_trigger_n_out,
    output logic                      bus_trigger_n_oe,
    input  wire logic                 bus_ready_in,
    output logic                      bus_ready_out,
    output logic                      bus_ready_oe,
    input  wire logic                 bus_execute_n_in,
    output logic                      bus_execute_n_out,
    output logic                      bus_execute_n_oe,
    // Rear edge trigger pin
    input  wire logic                 edge_trig_in,
    output logic                      edge_trig_out,
    output logic                      edge_trig_oe,
    // Internal trigger lines, visible for debug
    output logic                      line_a,
    output logic                      line_b
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic hits_a(input logic [1:0] r);
        return r == ctcp_pkg::ROUTE_LINEA || r == ctcp_pkg::ROUTE_BOTH;
    endfunction

    function automatic logic hits_b(input logic [1:0] r);
        return r == ctcp_pkg::ROUTE_LINEB || r == ctcp_pkg::ROUTE_BOTH;
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [3:0]          raw_in;
    logic [3:0]          syn_in;
    ctcp_pkg::ctcp_bus_s bus_s;
    logic                edge_s;

    // Convert bus to true sense before the synchroniser
    assign raw_in = {~bus_trigger_n_in, bus_ready_in, ~bus_execute_n_in, edge_trig_in};

    ctcp_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (raw_in),
        .sync_out (syn_in)
    );

    assign bus_s  = ctcp_pkg::ctcp_bus_s'(syn_in[3:1]);
    assign edge_s = syn_in[0];

    // ---------------------------------------------------------------
    // Edge and level detection
    // ---------------------------------------------------------------
    logic edge_d;
    logic exec_d;
    logic ready_d;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            edge_d  <= 1'b0;
            exec_d  <= 1'b0;
            ready_d <= 1'b0;
        end else if (clk_en) begin
            edge_d  <= edge_s;
            exec_d  <= bus_s.execute;
            ready_d <= bus_s.ready;
        end
    end

    logic edge_rise;
    logic exec_rise;
    logic ready_rise;
    logic ready_fall;

    assign edge_rise  = edge_s & ~edge_d;
    assign exec_rise  = bus_s.execute & ~exec_d;
    assign ready_rise = bus_s.ready & ~ready_d;
    assign ready_fall = ~bus_s.ready & ready_d;

    // ---------------------------------------------------------------
    // Execute pulse mask: own trigger inputs ignore the forced pulse
    // ---------------------------------------------------------------
    logic [ctcp_pkg::CNT_W-1:0] pulse_cnt;
    logic [ctcp_pkg::CNT_W-1:0] mask_cnt;
    logic                       pulse_on;
    logic                       masked;

    assign pulse_on = pulse_cnt != '0;
    assign masked   = mask_cnt != '0;

    // Counters restart on every execute edge, coordinated or not
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt <= '0;
            mask_cnt  <= '0;
        end else if (clk_en) begin
            if (exec_rise) begin
                pulse_cnt <= ctcp_pkg::CNT_W'(ctcp_pkg::EXEC_TRIG_CYCLES);
                mask_cnt  <= ctcp_pkg::CNT_W'(ctcp_pkg::EXEC_MASK_CYCLES);
            end else begin
                if (pulse_on) begin
                    pulse_cnt <= pulse_cnt - 1'b1;
                end
                if (masked) begin
                    mask_cnt <= mask_cnt - 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Received triggers and internal lines
    // ---------------------------------------------------------------
    logic bus_trig_rx;
    logic edge_trig_rx;
    logic next_line_a;
    logic next_line_b;

    // Level sense on bus, edge sense on rear input; pulse window blanked
    assign bus_trig_rx  = bus_s.trigger & ~masked;
    assign edge_trig_rx = edge_rise;

    // Line a always carries the analyzer trigger
    assign next_line_a = ana_trigger
                       | (bus_trig_rx  & hits_a(cfg.bus_in_route))
                       | (edge_trig_rx & hits_a(cfg.edge_in_route));
    assign next_line_b = (bus_trig_rx  & hits_b(cfg.bus_in_route))
                       | (edge_trig_rx & hits_b(cfg.edge_in_route));

    // ---------------------------------------------------------------
    // Coordination state machine
    // ---------------------------------------------------------------
    ctcp_pkg::ctcp_state_e state;
    ctcp_pkg::ctcp_state_e next_state;
    logic                  next_run;

    // Coordination off: execute and ready do not move the state machine
    always_comb begin
        next_state = state;
        next_run   = 1'b0;
        case (state)
            ctcp_pkg::CTCP_IDLE: begin
                if (coord_en) begin
                    next_state = ctcp_pkg::CTCP_HALT;
                end
            end
            ctcp_pkg::CTCP_RUN: begin
                if (!coord_en) begin
                    next_state = ctcp_pkg::CTCP_IDLE;
                end else if (exec_rise) begin
                    next_state = ctcp_pkg::CTCP_ARMED;
                end else if (emu_break || ready_fall || !bus_s.ready) begin
                    next_state = ctcp_pkg::CTCP_HALT;
                end
            end
            ctcp_pkg::CTCP_HALT: begin
                if (!coord_en) begin
                    next_state = ctcp_pkg::CTCP_IDLE;
                end else if (exec_rise) begin
                    next_state = ctcp_pkg::CTCP_ARMED;
                end else if (bus_s.ready && emu_prepared && !emu_break) begin
                    next_state = ctcp_pkg::CTCP_RUN;
                end
            end
            ctcp_pkg::CTCP_ARMED: begin
                if (!coord_en) begin
                    next_state = ctcp_pkg::CTCP_IDLE;
                end else if (bus_s.ready && emu_prepared && !emu_break) begin
                    next_state = ctcp_pkg::CTCP_RUN;
                    next_run   = 1'b1;
                end
            end
            default: begin
                next_state = ctcp_pkg::CTCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ctcp_pkg::CTCP_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // Output decode
    // ---------------------------------------------------------------
    logic in_coord;
    logic next_pull_ready;
    logic next_brk;
    logic next_bus_trig;
    logic next_edge_trig;
    logic next_arm;
    logic next_exec_start;
    logic out_lvl_d;

    assign in_coord = state != ctcp_pkg::CTCP_IDLE;

    // Stopped unit frees ready once prepared, else the wired AND never rises
    assign next_pull_ready = ((next_state == ctcp_pkg::CTCP_HALT)
                              | (next_state == ctcp_pkg::CTCP_ARMED))
                           & (~emu_prepared | emu_break)
                           | ((next_state == ctcp_pkg::CTCP_RUN) & emu_break);

    // Break on line a, optional line b, direct externals, or coordinated stop
    assign next_brk = next_line_a
                    | (next_line_b & cfg.emu_brk_on_b)
                    | (bus_trig_rx & cfg.bus_brk_direct)
                    | (edge_trig_rx & cfg.edge_brk_direct)
                    | (in_coord & coord_en & ~bus_s.ready & ~emu_in_monitor);

    // Bus trigger: routed internal lines, plus the forced execute pulse
    assign next_bus_trig = (next_line_a & hits_a(cfg.bus_out_route))
                         | (next_line_b & hits_b(cfg.bus_out_route))
                         | pulse_on;

    // Rear output level from routed lines; stretched one cycle so a rise shows
    assign next_edge_trig = ((next_line_a & hits_a(cfg.edge_out_route))
                           | (next_line_b & hits_b(cfg.edge_out_route)));

    assign next_arm        = next_line_b & cfg.ana_arm_on_b;
    assign next_exec_start = exec_rise;

    // Registered outputs; reset pulls ready low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_ready_out      <= 1'b0;
            bus_ready_oe       <= 1'b1;
            bus_trigger_n_out  <= 1'b0;
            bus_trigger_n_oe   <= 1'b0;
            bus_execute_n_out  <= 1'b0;
            bus_execute_n_oe   <= 1'b0;
            edge_trig_out      <= 1'b0;
            edge_trig_oe       <= 1'b0;
            out_lvl_d          <= 1'b0;
            emu_break_req      <= 1'b0;
            emu_run_from_start <= 1'b0;
            emu_hold           <= 1'b0;
            ana_arm            <= 1'b0;
            ana_exec_start     <= 1'b0;
            line_a             <= 1'b0;
            line_b             <= 1'b0;
        end else if (clk_en) begin
            bus_ready_out      <= 1'b0;
            bus_ready_oe       <= next_pull_ready;
            bus_trigger_n_out  <= 1'b0;
            bus_trigger_n_oe   <= next_bus_trig;
            bus_execute_n_out  <= 1'b0;
            bus_execute_n_oe   <= exec_request;
            out_lvl_d          <= next_edge_trig;
            edge_trig_out      <= next_edge_trig | out_lvl_d;
            edge_trig_oe       <= next_edge_trig | out_lvl_d;
            emu_break_req      <= next_brk;
            emu_run_from_start <= next_run;
            emu_hold           <= next_state == ctcp_pkg::CTCP_HALT
                                | next_state == ctcp_pkg::CTCP_ARMED;
            ana_arm            <= next_arm;
            ana_exec_start     <= next_exec_start;
            line_a             <= next_line_a;
            line_b             <= next_line_b;
        end
    end

endmodule

//--- tb/ctcp_port_asserts.sv
// Port-level assertions for the coordination port
`timescale 1ns/1ps
module ctcp_port_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Inputs that cause reactions
    input wire logic coord_en,
    input wire logic emu_break,
    input wire logic exec_request,
    input wire logic ana_trigger,
    input wire logic bus_ready_in,
    // Outputs under watch
    input wire logic emu_hold,
    input wire logic emu_run_from_start,
    input wire logic ana_exec_start,
    input wire logic bus_trigger_n_oe,
    input wire logic bus_ready_oe,
    input wire logic bus_execute_n_oe,
    input wire logic bus_execute_n_out,
    input wire logic line_a
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Reset must not be masked here, it is the cause itself
    property p_rst_ready; disable iff (1'b0) !rst_b [*2] |-> bus_ready_oe; endproperty
    a_rst_ready: assert property (p_rst_ready) else $error("ready free in reset");
    property p_exec_trig; $rose(ana_exec_start) |=> bus_trigger_n_oe [*4]; endproperty
    a_exec_trig: assert property (p_exec_trig) else $error("no trigger pulse");
    property p_exec_pulse; ana_exec_start |=> !ana_exec_start; endproperty
    a_exec_pulse: assert property (p_exec_pulse) else $error("exec start too long");
    property p_run; emu_run_from_start |-> coord_en && $past(emu_hold) ##1 !emu_run_from_start;
    endproperty
    a_run: assert property (p_run) else $error("bad run start");
    property p_off_idle; !coord_en [*3] |-> !emu_hold && !emu_run_from_start; endproperty
    a_off_idle: assert property (p_off_idle) else $error("held while off");
    property p_brk_ready; (coord_en && emu_break) [*3] |-> bus_ready_oe; endproperty
    a_brk_ready: assert property (p_brk_ready) else $error("ready free in break");
    property p_ready_hold; (coord_en && !bus_ready_in) [*4] |-> emu_hold; endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("runs on ready low");
    property p_line_a; ana_trigger [*3] |-> line_a; endproperty
    a_line_a: assert property (p_line_a) else $error("line a not driven");
    property p_exec_drv; exec_request |=> bus_execute_n_oe && !bus_execute_n_out; endproperty
    a_exec_drv: assert property (p_exec_drv) else $error("execute not driven");
endmodule

bind ctcp_port ctcp_port_asserts u_asserts (.clk_sys, .rst_b, .coord_en, .emu_break,
    .exec_request, .ana_trigger, .bus_ready_in, .emu_hold, .emu_run_from_start,
    .ana_exec_start, .bus_trigger_n_oe, .bus_ready_oe, .bus_execute_n_oe,
    .bus_execute_n_out, .line_a);

//--- tb/ctcp_peer_model.sv
// Peer units and rear instrument on the far side of the port
`timescale 1ns/1ps
module ctcp_peer_model #(
    parameter int unsigned PEERS = 31
) (
    // Clock
    input  wire logic             clk_sys,
    // Our unit's pin drivers
    input  wire logic             bus_trigger_n_oe,
    input  wire logic             bus_ready_oe,
    input  wire logic             bus_execute_n_oe,
    input  wire logic             edge_trig_out,
    input  wire logic             edge_trig_oe,
    // Bench commands
    input  wire logic [PEERS-1:0] peer_busy,
    input  wire logic             peer_exec,
    input  wire logic             peer_trig,
    input  wire logic             instr_edge,
    // Resolved lines
    output logic                  bus_trigger_n_in,
    output logic                  bus_ready_in,
    output logic                  bus_execute_n_in,
    output logic                  edge_trig_in
);
    logic [PEERS-1:0] busy_q;
    // Slow peers release ready one clock late
    always_ff @(posedge clk_sys) begin
        busy_q <= peer_busy;
    end
    // Pulled-up shared lines, any driver pulls low
    assign bus_trigger_n_in = !(bus_trigger_n_oe || peer_trig);
    assign bus_execute_n_in = !(bus_execute_n_oe || peer_exec);
    // Wired AND of up to 32 units' ready states
    assign bus_ready_in = !(bus_ready_oe || (|peer_busy) || (|busy_q));
    // Pulled-down rear line; instrument listens only here
    assign edge_trig_in = (edge_trig_oe && edge_trig_out) || instr_edge;
endmodule

//--- tb/test_ctcp_port.sv
// Self-checking bench for the coordination port
`timescale 1ns/1ps
module test_ctcp_port;
    localparam int EV_EDGE = 0, EV_ARM = 1, EV_BRK = 2, EV_RUN = 3, EV_EXEC = 4;
    logic                clk_sys, rst_b, coord_en, emu_break, emu_prepared;
    logic                emu_in_monitor, exec_request, ana_trigger;
    logic                peer_exec, peer_trig, instr_edge;
    logic [30:0]         peer_busy;
    ctcp_pkg::ctcp_cfg_s cfg;
    logic                emu_break_req, emu_run_from_start, emu_hold, ana_arm, ana_exec_start;
    logic                bus_trigger_n_out, bus_trigger_n_oe, bus_ready_out, bus_ready_oe;
    logic                bus_execute_n_out, bus_execute_n_oe, edge_trig_out, edge_trig_oe;
    logic                line_a, line_b;
    wire                 bus_trigger_n_in, bus_ready_in, bus_execute_n_in, edge_trig_in;
    int                  err_total, checks_done;
    logic [7:0]          scen;
    logic [7:0]          exp_q [5][$];
    logic [4:0]          ev, ev_prev;

    ctcp_port DUT (.clk_sys, .rst_b, .clk_en(1'b1), .coord_en, .cfg, .emu_break, .emu_prepared,
        .emu_in_monitor, .exec_request, .emu_break_req, .emu_run_from_start, .emu_hold,
        .ana_trigger, .ana_arm, .ana_exec_start, .bus_trigger_n_in, .bus_trigger_n_out,
        .bus_trigger_n_oe, .bus_ready_in, .bus_ready_out, .bus_ready_oe, .bus_execute_n_in,
        .bus_execute_n_out, .bus_execute_n_oe, .edge_trig_in, .edge_trig_out, .edge_trig_oe,
        .line_a, .line_b);
    ctcp_peer_model u_peers (.clk_sys, .bus_trigger_n_oe, .bus_ready_oe, .bus_execute_n_oe,
        .edge_trig_out, .edge_trig_oe, .peer_busy, .peer_exec, .peer_trig, .instr_edge,
        .bus_trigger_n_in, .bus_ready_in, .bus_execute_n_in, .edge_trig_in);

    // ------------------------------------------------------------
    // Helpers and scoreboard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic note(input int k);
        exp_q[k].push_back(scen);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: level %b, want %b, test %0d", $time, got, exp, scen);
        end
    endtask
    // Empty queue means an event nobody asked for
    task automatic chk_ev(input int k);
        logic [7:0] want;
        checks_done++;
        want = (exp_q[k].size() != 0) ? exp_q[k].pop_front() : 8'hFF;
        if (want !== scen) begin
            err_total++;
            $display("ERROR %0t: event %0d in test %0d, noted %0d", $time, k, scen, want);
        end
    endtask
    task automatic finish_test();
        cyc(20);
        for (int k = 0; k < 5; k++) begin
            checks_done++;
            if (exp_q[k].size() != 0) begin
                err_total++;
                $display("ERROR %0t: event %0d missing in test %0d", $time, k, scen);
            end
        end
        $display("Test %0d done", scen);
        scen = scen + 8'h01;
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watch rising outputs, sampled where settled
    always @(negedge clk_sys) begin
        ev = {ana_exec_start, emu_run_from_start, emu_break_req, ana_arm, edge_trig_out};
        for (int k = 0; k < 5; k++) begin
            if (ev[k] && !ev_prev[k]) chk_ev(k);
        end
        ev_prev = ev;
    end
    // Budget is several times the expected run
    initial begin
        #(ctcp_pkg::CLK_PERIOD_NS * 5000);
        err_total++;
        $display("ERROR %0t: run too long", $time);
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rst_b, coord_en, emu_break, emu_prepared, emu_in_monitor} = '0;
        {exec_request, ana_trigger, peer_exec, peer_trig, instr_edge} = '0;
        peer_busy = '0;
        cfg = '0;
        {scen, err_total, checks_done, ev_prev} = '0;
        void'($urandom(71007));
        cyc(6);
        chk_bit(bus_ready_oe, 1'b1);
        chk_bit(bus_trigger_n_oe, 1'b0);
        rst_b = 1'b1;
        finish_test();
        // Execute from a peer and from us; own trigger pulse must not loop back
        cfg.bus_in_route = ctcp_pkg::ROUTE_BOTH;
        {cfg.ana_arm_on_b, cfg.emu_brk_on_b, cfg.bus_brk_direct} = 3'h7;
        for (int s = 0; s < 2; s++) begin
            note(EV_EXEC);
            if (s == 0) peer_exec = 1'b1;
            else exec_request = 1'b1;
            cyc($urandom_range(1, 4));
            {peer_exec, exec_request} = 2'h0;
            finish_test();
        end
        // Bus trigger is level sensed: routing a held level reacts
        cfg = '0;
        cfg.ana_arm_on_b = 1'b1;
        peer_trig = 1'b1;
        cyc(10);
        note(EV_ARM);
        cfg.bus_in_route = ctcp_pkg::ROUTE_LINEB;
        cyc(8);
        note(EV_BRK);
        cfg.bus_brk_direct = 1'b1;
        cyc(8);
        peer_trig = 1'b0;
        finish_test();
        // Rear edge through every route code, then directly
        for (int r = 0; r < 5; r++) begin
            cfg = '0;
            cfg.edge_in_route = (r < 4) ? 2'(r) : ctcp_pkg::ROUTE_NONE;
            cfg.edge_brk_direct = (r == 4);
            {cfg.ana_arm_on_b, cfg.emu_brk_on_b} = 2'h3;
            if (r != 0) note(EV_BRK);
            if (r == 2 || r == 3) note(EV_ARM);
            instr_edge = 1'b1;
            cyc($urandom_range(4, 10));
            instr_edge = 1'b0;
            finish_test();
        end
        // Held rear level must not react once routed
        cfg = '0;
        instr_edge = 1'b1;
        cyc(6);
        cfg.edge_in_route = ctcp_pkg::ROUTE_LINEA;
        cyc(8);
        instr_edge = 1'b0;
        finish_test();
        // Analyzer trigger goes out on both external lines
        cfg = '0;
        cfg.bus_out_route = ctcp_pkg::ROUTE_LINEA;
        cfg.edge_out_route = ctcp_pkg::ROUTE_LINEA;
        note(EV_BRK);
        note(EV_EDGE);
        ana_trigger = 1'b1;
        cyc(3);
        chk_bit(bus_trigger_n_oe, 1'b1);
        chk_bit(bus_trigger_n_out, 1'b0);
        chk_bit(edge_trig_oe, 1'b1);
        chk_bit(bus_ready_out, 1'b0);
        cyc($urandom_range(1, 3));
        ana_trigger = 1'b0;
        finish_test();
        // Coordinated start, slow peer, then a peer break
        cfg = '0;
        emu_in_monitor = 1'b1;
        peer_busy = 31'h1;
        coord_en = 1'b1;
        cyc(6);
        chk_bit(emu_hold, 1'b1);
        chk_bit(bus_ready_oe, 1'b1);
        emu_prepared = 1'b1;
        cyc(6);
        chk_bit(bus_ready_oe, 1'b0);
        chk_bit(emu_hold, 1'b1);
        note(EV_EXEC);
        peer_exec = 1'b1;
        cyc(2);
        peer_exec = 1'b0;
        cyc($urandom_range(3, 12));
        note(EV_RUN);
        peer_busy = '0;
        cyc(8);
        chk_bit(emu_hold, 1'b0);
        emu_in_monitor = 1'b0;
        note(EV_BRK);
        peer_busy = 31'h1 << $urandom_range(30);
        cyc(6);
        chk_bit(emu_hold, 1'b1);
        emu_break = 1'b1;
        peer_busy = '0;
        cyc(8);
        chk_bit(bus_ready_oe, 1'b1);
        emu_break = 1'b0;
        coord_en = 1'b0;
        finish_test();
        conclude();
    end
endmodule
